// file: rtl/ssw_status_regs.vh
// Constants for the supply status word block
`ifndef SSW_STATUS_REGS_VH
`define SSW_STATUS_REGS_VH

// Word layout of the six-word supply status domain
`define SSW_DOMAIN_WORDS      6
`define SSW_WORD_UNIT_FIRST   3'h0
`define SSW_WORD_UNIT_LAST    3'h4
`define SSW_WORD_RESERVED     3'h5

// Status word bit positions
`define SSW_BIT_LINK_UP       15
`define SSW_BIT_UNUSED_HI     14
`define SSW_BIT_UNUSED_LO     11
`define SSW_BIT_READ_ERROR    10
`define SSW_BIT_FAN_WARN      9
`define SSW_BIT_FAN_FAIL      8
`define SSW_BIT_VALUE_HI      7
`define SSW_BIT_VALUE_LO      0
`define SSW_STATUS_RESET      16'h0000

// Monitor selection codes, seven valid choices
`define SSW_SEL_OUT_VOLT      3'h0
`define SSW_SEL_AUX_VOLT      3'h1
`define SSW_SEL_OUT_CURR      3'h2
`define SSW_SEL_PEAK_CURR     3'h3
`define SSW_SEL_LOAD          3'h4
`define SSW_SEL_FAN_SPEED     3'h5
`define SSW_SEL_TEMP          3'h6

// Raw-to-code divisors (raw units: 0.1 V, 0.01 A, 0.1 %, 1 r/min, 0.1 C)
`define SSW_DIV_VOLT          7'h0a
`define SSW_DIV_CURR          7'h0a
`define SSW_DIV_LOAD          7'h0a
`define SSW_DIV_FAN           7'h64
`define SSW_DIV_TEMP          7'h0a
`define SSW_VALUE_MAX         8'hff

// Fan supervision
`define SSW_PCT_FULL          24'd100
`define SSW_FAN_WARN_DROP     24'd30
`define SSW_FAN_FAIL_DROP     24'd50
`define SSW_CODE_FAN_WARN     12'h04c
`define SSW_CODE_FAN_FAIL     12'h0d6
`define SSW_CODE_NONE         12'h000

// Timing
`define SSW_CLK_MHZ           20
`define SSW_FAN_SAMPLE_US     1000

`endif

// file: rtl/ssw_value_mem.v
// Small value memory with registered read data
`default_nettype none

module ssw_value_mem #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             wr_en,
    input  wire [AW-1:0]    wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             rd_en,
    input  wire [AW-1:0]    rd_addr,
    output reg  [WIDTH-1:0] rd_data_r
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    integer         i;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= {WIDTH{1'b0}};
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= {WIDTH{1'b0}};
        end else if (rd_en) begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

endmodule // ssw_value_mem

`default_nettype wire

// file: rtl/ssw_status_word.v
// Supply status word assembly for up to five power supply units
//
// Overview of operation
// - Bit 15 is set only while the unit link is firmly established and the unit is accepted as enabled.
// - Bit 10 is set whenever monitored data acquisition from the unit fails.
// - A fan speed drop of 30 percent raises message alarm 04C and sets the fan warning at bit 9.
// - Both fan flags stand while their alarm is active and clear when the alarm is cancelled, unless a fan sample tick in that same cycle still finds the drop.
// - A fan speed drop of 50 percent raises cancel alarm 0D6, stops the actuator and sets bit 8.
// - Bits 7 to 0 carry the value of the single monitored quantity chosen by configuration.
// - Seven quantities are selectable and only one occupies the low byte at a time.
// - Output and auxiliary winding voltage are coded in 1 V steps from 0 to 255 V.
// - Output and peak hold current are coded in 0.1 A steps from 0 to 25.5 A.
// - Load factor is coded in 1 percent steps from 0 to 255 percent.
// - Fan speed is coded in 100 r/min steps from 0 to 25500 r/min.
// - Board temperature is coded in 1 degree steps from 0 to 255 degrees.
// - Six words form the domain and the first five hold the status words of units 0 to 4.
`include "ssw_status_regs.vh"
`default_nettype none

module ssw_status_word #(
    parameter NUM_UNITS      = 5,
    parameter FAN_SAMPLE_CYC = `SSW_FAN_SAMPLE_US * `SSW_CLK_MHZ
) (
    input  wire                    ref_clk,
    input  wire                    arst_n,
    input  wire [NUM_UNITS-1:0]    comm_established,
    input  wire [NUM_UNITS-1:0]    unit_enabled,
    input  wire [NUM_UNITS-1:0]    acquire_fail,
    input  wire [NUM_UNITS-1:0]    alarm_cancel,
    input  wire [NUM_UNITS*3-1:0]  monitor_sel,
    input  wire [NUM_UNITS*16-1:0] raw_out_volt,
    input  wire [NUM_UNITS*16-1:0] raw_aux_volt,
    input  wire [NUM_UNITS*16-1:0] raw_out_curr,
    input  wire [NUM_UNITS*16-1:0] raw_peak_curr,
    input  wire [NUM_UNITS*16-1:0] raw_load,
    input  wire [NUM_UNITS*16-1:0] raw_fan_rpm,
    input  wire [NUM_UNITS*16-1:0] raw_temp,
    input  wire [NUM_UNITS*16-1:0] fan_nominal_rpm,
    input  wire                    rd_en,
    input  wire [2:0]              rd_word,
    output wire [15:0]             rd_data,
    output reg                     rd_valid_r,
    output reg  [NUM_UNITS-1:0]    fan_slow_warning,
    output reg  [NUM_UNITS-1:0]    fan_fail_alarm,
    output wire [NUM_UNITS-1:0]    actuator_stop,
    output reg  [NUM_UNITS*12-1:0] fan_alarm_code
);

    localparam [1:0]  S_LOAD  = 2'h0;
    localparam [1:0]  S_DIV   = 2'h1;
    localparam [1:0]  S_STORE = 2'h2;
    localparam integer TICK_LAST_I = FAN_SAMPLE_CYC - 1;
    localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

    reg                 rst_meta_r;
    reg                 rst_sync_r;
    reg [15:0]          tick_cnt_r;
    reg                 tick_r;
    reg [1:0]           state_r;
    reg [1:0]           state_nxt;
    reg [2:0]           unit_r;
    reg [15:0]          dvd_r;
    reg [6:0]           dsr_r;
    reg [7:0]           rem_r;
    reg [15:0]          quo_r;
    reg [4:0]           bit_cnt_r;
    reg                 skip_r;
    reg                 zero_r;
    reg [7:0]           flags_r;
    reg [NUM_UNITS-1:0] cond_warn;
    reg [NUM_UNITS-1:0] cond_fail;
    wire [7:0]          mem_rdata;
    wire [7:0]          rem_shift;
    wire                rem_ge;
    wire [7:0]          coded;
    wire                store_en;
    wire [2:0]          cur_sel;
    wire                cur_link;
    wire                rd_is_unit;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function [6:0] sel_divisor;
        input [2:0] sel;
        begin
            case (sel)
                `SSW_SEL_OUT_VOLT:  sel_divisor = `SSW_DIV_VOLT;
                `SSW_SEL_AUX_VOLT:  sel_divisor = `SSW_DIV_VOLT;
                `SSW_SEL_OUT_CURR:  sel_divisor = `SSW_DIV_CURR;
                `SSW_SEL_PEAK_CURR: sel_divisor = `SSW_DIV_CURR;
                `SSW_SEL_LOAD:      sel_divisor = `SSW_DIV_LOAD;
                `SSW_SEL_FAN_SPEED: sel_divisor = `SSW_DIV_FAN;
                `SSW_SEL_TEMP:      sel_divisor = `SSW_DIV_TEMP;
                default:            sel_divisor = 7'h01;
            endcase
        end
    endfunction

    function sel_valid;
        input [2:0] sel;
        begin
            sel_valid = (sel <= `SSW_SEL_TEMP);
        end
    endfunction

    function unit_link;
        input [2:0]           u;
        input [NUM_UNITS-1:0] est;
        input [NUM_UNITS-1:0] ena;
        begin
            unit_link = est[u] & ena[u];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fan sample enable
    always @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= 16'h0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 16'h0001;
            tick_r     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fan supervision per unit
    genvar g;
    generate
        for (g = 0; g < NUM_UNITS; g = g + 1) begin : g_fan
            wire [23:0] rpm_scaled = {8'h00, raw_fan_rpm[g*16 +: 16]} * `SSW_PCT_FULL;
            wire [23:0] warn_lim   = {8'h00, fan_nominal_rpm[g*16 +: 16]} * (`SSW_PCT_FULL - `SSW_FAN_WARN_DROP);
            wire [23:0] fail_lim   = {8'h00, fan_nominal_rpm[g*16 +: 16]} * (`SSW_PCT_FULL - `SSW_FAN_FAIL_DROP);
            wire        watch      = comm_established[g] & unit_enabled[g] & ~acquire_fail[g]
                                     & (fan_nominal_rpm[g*16 +: 16] != 16'h0000);

            always @* begin
                cond_warn[g] = watch & (rpm_scaled <= warn_lim);
                cond_fail[g] = watch & (rpm_scaled <= fail_lim);
            end

            always @(posedge ref_clk or negedge rst_sync_r) begin
                if (!rst_sync_r) begin
                    fan_slow_warning[g] <= 1'b0;
                    fan_fail_alarm[g]   <= 1'b0;
                end else begin
                    if (tick_r && cond_warn[g]) begin
                        fan_slow_warning[g] <= 1'b1;
                    end else if (alarm_cancel[g]) begin
                        fan_slow_warning[g] <= 1'b0;
                    end
                    if (tick_r && cond_fail[g]) begin
                        fan_fail_alarm[g] <= 1'b1;
                    end else if (alarm_cancel[g]) begin
                        fan_fail_alarm[g] <= 1'b0;
                    end
                end
            end

            always @(posedge ref_clk or negedge rst_sync_r) begin
                if (!rst_sync_r) begin
                    fan_alarm_code[g*12 +: 12] <= `SSW_CODE_NONE;
                end else if (fan_fail_alarm[g]) begin
                    fan_alarm_code[g*12 +: 12] <= `SSW_CODE_FAN_FAIL;
                end else if (fan_slow_warning[g]) begin
                    fan_alarm_code[g*12 +: 12] <= `SSW_CODE_FAN_WARN;
                end else begin
                    fan_alarm_code[g*12 +: 12] <= `SSW_CODE_NONE;
                end
            end

            assign actuator_stop[g] = fan_fail_alarm[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Unit scan and value conversion
    assign cur_sel   = monitor_sel[unit_r*3 +: 3];
    assign cur_link  = unit_link(unit_r, comm_established, unit_enabled);
    assign rem_shift = {rem_r[6:0], dvd_r[15]};
    assign rem_ge    = (rem_shift >= {1'b0, dsr_r});
    assign coded     = (quo_r[15:8] != 8'h00) ? `SSW_VALUE_MAX : quo_r[7:0];
    assign store_en  = (state_r == S_STORE) && !skip_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_LOAD:  state_nxt = S_DIV;
            S_DIV:   state_nxt = (bit_cnt_r == 5'h0f) ? S_STORE : S_DIV;
            S_STORE: state_nxt = S_LOAD;
            default: state_nxt = S_LOAD;
        endcase
    end

    always @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            state_r   <= S_LOAD;
            unit_r    <= 3'h0;
            dvd_r     <= 16'h0000;
            dsr_r     <= 7'h01;
            rem_r     <= 8'h00;
            quo_r     <= 16'h0000;
            bit_cnt_r <= 5'h00;
            skip_r    <= 1'b0;
            zero_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            case (state_r)
                S_LOAD: begin
                    rem_r     <= 8'h00;
                    quo_r     <= 16'h0000;
                    bit_cnt_r <= 5'h00;
                    dsr_r     <= sel_divisor(cur_sel);
                    skip_r    <= acquire_fail[unit_r];
                    zero_r    <= !cur_link || !sel_valid(cur_sel);
                    case (cur_sel)
                        `SSW_SEL_OUT_VOLT:  dvd_r <= raw_out_volt[unit_r*16 +: 16];
                        `SSW_SEL_AUX_VOLT:  dvd_r <= raw_aux_volt[unit_r*16 +: 16];
                        `SSW_SEL_OUT_CURR:  dvd_r <= raw_out_curr[unit_r*16 +: 16];
                        `SSW_SEL_PEAK_CURR: dvd_r <= raw_peak_curr[unit_r*16 +: 16];
                        `SSW_SEL_LOAD:      dvd_r <= raw_load[unit_r*16 +: 16];
                        `SSW_SEL_FAN_SPEED: dvd_r <= raw_fan_rpm[unit_r*16 +: 16];
                        `SSW_SEL_TEMP:      dvd_r <= raw_temp[unit_r*16 +: 16];
                        default:            dvd_r <= 16'h0000;
                    endcase
                end
                S_DIV: begin
                    dvd_r     <= {dvd_r[14:0], 1'b0};
                    rem_r     <= rem_ge ? (rem_shift - {1'b0, dsr_r}) : rem_shift;
                    quo_r     <= {quo_r[14:0], rem_ge};
                    bit_cnt_r <= bit_cnt_r + 5'h01;
                end
                S_STORE: begin
                    if (unit_r == NUM_UNITS - 1) begin
                        unit_r <= 3'h0;
                    end else begin
                        unit_r <= unit_r + 3'h1;
                    end
                end
                default: begin
                    unit_r <= 3'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitored value storage
    ssw_value_mem #(
        .WIDTH (8),
        .DEPTH (8),
        .AW    (3)
    ) u_value_mem (
        .clk       (ref_clk),
        .rst_n     (rst_sync_r),
        .wr_en     (store_en),
        .wr_addr   (unit_r),
        .wr_data   (zero_r ? 8'h00 : coded),
        .rd_en     (rd_en),
        .rd_addr   (rd_word),
        .rd_data_r (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host read of the status domain
    assign rd_is_unit = (rd_word <= `SSW_WORD_UNIT_LAST) && (rd_word < NUM_UNITS);

    always @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            flags_r    <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= rd_en;
            if (rd_en) begin
                if (rd_is_unit) begin
                    flags_r[7] <= unit_link(rd_word, comm_established, unit_enabled);
                    flags_r[6] <= 1'b0;
                    flags_r[5] <= 1'b0;
                    flags_r[4] <= 1'b0;
                    flags_r[3] <= 1'b0;
                    flags_r[2] <= acquire_fail[rd_word];
                    flags_r[1] <= fan_slow_warning[rd_word];
                    flags_r[0] <= fan_fail_alarm[rd_word];
                end else begin
                    flags_r <= 8'h00;
                end
            end
        end
    end

    reg rd_unit_r;
    always @(posedge ref_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            rd_unit_r <= 1'b0;
        end else if (rd_en) begin
            rd_unit_r <= rd_is_unit;
        end
    end

    assign rd_data = {flags_r, rd_unit_r ? mem_rdata : 8'h00};

endmodule // ssw_status_word

`default_nettype wire

// file: verification/ssw_host_model.sv
// Host controller model reading status words
`default_nettype none
module ssw_host_model (
    input  wire logic        ref_clk,
    output var  logic        rd_en,
    output var  logic [2:0]  rd_word,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid_r
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rd_en = 1'b0;
        rd_word = 3'h0;
    end
    // One strobe, then a bounded wait for the answer
    task automatic read_word(input logic [2:0] w, output logic [15:0] d, output bit ok);
        ok = 1'b0;
        d = 16'h0;
        @(negedge ref_clk);
        rd_en = 1'b1;
        rd_word = w;
        @(negedge ref_clk);
        rd_en = 1'b0;
        rd_word = ~w;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (rd_valid_r === 1'b1) begin
                d = rd_data;
                ok = 1'b1;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask
endmodule // ssw_host_model
`default_nettype wire

// file: verification/ssw_status_monitor.sv
// Assertion checker for the supply status word block
`default_nettype none
module ssw_status_monitor #(
    parameter int NUM_UNITS      = 5,
    parameter int FAN_SAMPLE_CYC = 8
) (
    input wire logic                    ref_clk,
    input wire logic                    arst_n,
    input wire logic [NUM_UNITS-1:0]    comm_established,
    input wire logic [NUM_UNITS-1:0]    unit_enabled,
    input wire logic [NUM_UNITS-1:0]    acquire_fail,
    input wire logic [NUM_UNITS-1:0]    alarm_cancel,
    input wire logic                    rd_en,
    input wire logic [2:0]              rd_word,
    input wire logic [15:0]             rd_data,
    input wire logic                    rd_valid_r,
    input wire logic [NUM_UNITS-1:0]    fan_slow_warning,
    input wire logic [NUM_UNITS-1:0]    fan_fail_alarm,
    input wire logic [NUM_UNITS-1:0]    actuator_stop,
    input wire logic [NUM_UNITS*12-1:0] fan_alarm_code
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] w_r;
    logic [3:0] hi_r;
    logic [1:0] fl_r;
    // Live flags of the word taken by each read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            w_r <= 3'h0;
            hi_r <= 4'h0;
            fl_r <= 2'h0;
        end else begin
            fl_r <= {fan_fail_alarm[0], fan_slow_warning[0]};
            if (rd_en) begin
                w_r <= rd_word;
                hi_r <= 4'h0;
                if (rd_word < NUM_UNITS) begin
                    hi_r <= {comm_established[rd_word] & unit_enabled[rd_word], acquire_fail[rd_word],
                             fan_slow_warning[rd_word], fan_fail_alarm[rd_word]};
                end
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (rd_en |=> rd_valid_r)
        else $error("read answer missing");
    a_no_stray: assert property (!rd_en |=> !rd_valid_r)
        else $error("answer without read");
    a_unused_zero: assert property (rd_valid_r |-> rd_data[14:11] == 4'h0)
        else $error("unused bits set");
    a_link_bit: assert property (rd_valid_r |-> rd_data[15] == hi_r[3])
        else $error("link bit wrong");
    a_read_err_bit: assert property (rd_valid_r |-> rd_data[10] == hi_r[2])
        else $error("read error bit wrong");
    a_fan_bits: assert property (rd_valid_r |-> rd_data[9:8] == hi_r[1:0])
        else $error("fan bits wrong");
    a_spare_words: assert property (rd_valid_r && w_r >= NUM_UNITS |-> rd_data == 16'h0000)
        else $error("spare word not zero");
    a_stop_on_fail: assert property (actuator_stop == fan_fail_alarm)
        else $error("stop differs from fail");
    a_alarm_code: assert property (fan_alarm_code[11:0] ==
                  (fl_r[1] ? 12'h0d6 : fl_r[0] ? 12'h04c : 12'h000))
        else $error("alarm code wrong");
    a_fail_has_warn: assert property (fan_fail_alarm[0] |-> fan_slow_warning[0])
        else $error("fail without warn");
    a_warn_holds: assert property (fan_slow_warning[0] && !alarm_cancel[0] |=> fan_slow_warning[0])
        else $error("warn dropped");
    c_read_err: cover property (rd_valid_r && rd_data[10]);
    c_fan_fail: cover property (fan_fail_alarm[0]);
    c_spare: cover property (rd_valid_r && w_r >= NUM_UNITS);
endmodule // ssw_status_monitor
bind ssw_status_word ssw_status_monitor #(.NUM_UNITS(NUM_UNITS), .FAN_SAMPLE_CYC(FAN_SAMPLE_CYC)) u_mon (
    .ref_clk(ref_clk), .arst_n(arst_n), .comm_established(comm_established), .unit_enabled(unit_enabled),
    .acquire_fail(acquire_fail), .alarm_cancel(alarm_cancel), .rd_en(rd_en), .rd_word(rd_word),
    .rd_data(rd_data), .rd_valid_r(rd_valid_r), .fan_slow_warning(fan_slow_warning),
    .fan_fail_alarm(fan_fail_alarm), .actuator_stop(actuator_stop), .fan_alarm_code(fan_alarm_code));
`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the supply status word block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 5;
    logic            ref_clk = 1'b0;
    logic            arst_n = 1'b0;
    logic [N-1:0]    comm = '0;
    logic [N-1:0]    ena = '0;
    logic [N-1:0]    afail = '0;
    logic [N-1:0]    canc = '0;
    logic [N*3-1:0]  sel = '0;
    logic [N*16-1:0] rv [7];
    logic [N*16-1:0] nom = '0;
    logic            rd_en;
    logic [2:0]      rd_word;
    logic [15:0]     rd_data;
    logic            rd_valid_r;
    logic [N-1:0]    warn;
    logic [N-1:0]    fail;
    logic [N-1:0]    stop;
    logic [N*12-1:0] code;
    logic [7:0]      ev [N];
    logic [N-1:0]    ew = '0;
    logic [N-1:0]    ef = '0;
    int              miscompares = 0;
    int              num_checks = 0;
    ssw_status_word #(.NUM_UNITS(N), .FAN_SAMPLE_CYC(8)) dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .comm_established(comm), .unit_enabled(ena),
        .acquire_fail(afail), .alarm_cancel(canc), .monitor_sel(sel), .raw_out_volt(rv[0]),
        .raw_aux_volt(rv[1]), .raw_out_curr(rv[2]), .raw_peak_curr(rv[3]), .raw_load(rv[4]),
        .raw_fan_rpm(rv[5]), .raw_temp(rv[6]), .fan_nominal_rpm(nom), .rd_en(rd_en),
        .rd_word(rd_word), .rd_data(rd_data), .rd_valid_r(rd_valid_r), .fan_slow_warning(warn),
        .fan_fail_alarm(fail), .actuator_stop(stop), .fan_alarm_code(code));
    ssw_host_model host (
        .ref_clk(ref_clk), .rd_en(rd_en), .rd_word(rd_word), .rd_data(rd_data), .rd_valid_r(rd_valid_r));
    ////////////////////////////////////////
    // Expected low byte: scale, then saturate
    function automatic logic [7:0] exp_val(input logic [2:0] s, input logic [15:0] r);
        int q;
        q = (s == 3'h7) ? 0 : (s == 3'h5) ? int'(r) / 100 : int'(r) / 10;
        return (q > 255) ? 8'hff : q[7:0];
    endfunction
    function automatic logic [15:0] exp_word(input int u);
        if (u >= N) return 16'h0000;
        return {comm[u] & ena[u], 4'h0, afail[u], ew[u], ef[u], ev[u]};
    endfunction
    task automatic upd_ev(input int u);
        ev[u] = (comm[u] & ena[u]) ? exp_val(sel[u*3+:3], rv[sel[u*3+:3]][u*16+:16]) : 8'h00;
    endtask
    task automatic summarize();
        if (miscompares == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic read_chk(input int w);
        logic [15:0] d;
        bit          ok;
        host.read_word(w[2:0], d, ok);
        if (!ok) begin
            miscompares++;
            summarize();
        end else begin
            chk($sformatf("word %0d", w), exp_word(w), d);
        end
    endtask
    task automatic fan_chk();
        chk("fan warn", {15'h0, ew[0]}, {15'h0, warn[0]});
        chk("fan fail", {15'h0, ef[0]}, {15'h0, fail[0]});
        chk("stop", {15'h0, ef[0]}, {15'h0, stop[0]});
        chk("code", {4'h0, ef[0] ? 12'h0d6 : ew[0] ? 12'h04c : 12'h000}, {4'h0, code[11:0]});
        read_chk(0);
    endtask
    ////////////////////////////////////////
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        logic [15:0] rpm_t [6];
        logic [1:0]  exp_t [6];
        for (int q = 0; q < 7; q++) rv[q] = '0;
        rpm_t = '{16'd7001, 16'd7000, 16'd5001, 16'd5000, 16'd10000, 16'd10000};
        exp_t = '{2'b00, 2'b10, 2'b10, 2'b11, 2'b11, 2'b00};
        void'($urandom(23));
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Boundary pass, selection sweep, then random values
        for (int it = 0; it < 5; it++) begin
            for (int u = 0; u < N; u++) begin
                sel[u*3+:3] = (it < 2) ? 3'(u + it * 3) : 3'($urandom_range(0, 7));
                comm[u] = (it == 0) ? 1'b1 : 1'($urandom);
                ena[u] = (it == 0) ? 1'b1 : 1'($urandom);
                for (int q = 0; q < 7; q++) begin
                    rv[q][u*16+:16] = (it == 0) ? 16'((q == 5 ? 25599 : 2559) + u)
                                                : 16'($urandom_range(0, q == 5 ? 30000 : 3000));
                end
                upd_ev(u);
            end
            repeat (200) @(negedge ref_clk);
            for (int w = 0; w < 8; w++) begin
                read_chk(w);
            end
        end
        // Failed acquisition keeps the old value
        afail[2] = 1'b1;
        for (int q = 0; q < 7; q++) rv[q][32+:16] = 16'd1230;
        repeat (200) @(negedge ref_clk);
        read_chk(2);
        afail[2] = 1'b0;
        upd_ev(2);
        repeat (200) @(negedge ref_clk);
        read_chk(2);
        // Fan supervision on unit 0
        comm[0] = 1'b1;
        ena[0] = 1'b1;
        sel[2:0] = 3'h6;
        rv[5][15:0] = 16'd10000;
        nom[15:0] = 16'd10000;
        upd_ev(0);
        repeat (200) @(negedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            rv[5][15:0] = rpm_t[i];
            canc[0] = (i == 5);
            @(negedge ref_clk);
            canc[0] = 1'b0;
            repeat (30) @(negedge ref_clk);
            {ew[0], ef[0]} = exp_t[i];
            fan_chk();
        end
        summarize();
    end
endmodule // tb
`default_nettype wire
